// ===== include/lbcs_pkg.sv
// constants for the led boost control sequencer
package lbcs_pkg;
    localparam int          CLK_HZ           = 25000000;
    localparam int          SW_FREQ_HZ       = 600000;
    localparam int          SW_DIV           = CLK_HZ / SW_FREQ_HZ;
    localparam int          STEP_TIME_NS     = 213000;
    localparam int          STEP_CYC         = (STEP_TIME_NS * 25 + 999) / 1000;
    localparam int          RAMP_STEPS       = 32;
    localparam int          HALF_LIM_TIME_NS = 5000000;
    localparam int          HALF_LIM_CYC     = (HALF_LIM_TIME_NS / 1000) * 25;
    localparam int          OFF_TIME_NS      = 2500000;
    localparam int          OFF_CYC          = (OFF_TIME_NS / 1000) * 25;
    localparam int          OPEN_RUN         = 8;
    localparam int          REF_MV           = 200;
    localparam int          OVP_LOW_MV       = 26000;
    localparam int          OVP_HIGH_MV      = 38000;
    localparam int          TGT_W            = 8;
    localparam logic [7:0]  TGT_FULL         = 8'h_FF;
    localparam int          FILT_SHIFT       = 6;
endpackage

// ===== rtl/lbcs_top.sv
// digital sequencer for a fixed-frequency boost led driver
`timescale 1ns/1ns
// Summary of operation
// - switch runs at fixed 600kHz; timers count 25 MHz clocks, only the open count uses that switching tick.
// - after enable, target climbs 0 to full in 32 equal steps of 213us.
// - first 5ms after ramp start, current limit is halved, then restored.
// - open condition held for 8 consecutive switching cycles shuts switch off.
// - open means switch node above threshold and feedback below half target.
// - open fault latches off until host toggles control pin or undervoltage drops it to shutdown.
// - switch node threshold is per-variant parameter, 26V or 38V.
// - control low longer than 2.5ms enters shutdown; shorter lows dim.
// - control steadily high regulates to the full 200mV reference.
// - reference gated by control pin; target equals duty times full.
// - gated reference low-pass filtered before use as amplifier target.
// - target depends on duty alone, not on the pin high level.
// - undervoltage holds shutdown with switch off; restart on release.
module lbcs_top #(
    parameter bit          HIGH_VARIANT = 1'b0,              // voltage option select
    parameter int          OFF_CYCLES   = lbcs_pkg::OFF_CYC, // shutdown delay
    parameter int          HALF_CYCLES  = lbcs_pkg::HALF_LIM_CYC, // half limit window
    parameter int          STEP_CYCLES  = lbcs_pkg::STEP_CYC // staircase step
) (
    input  wire logic      CLK_IN,             // 25 MHz clock
    input  wire logic      NRST_IN,            // async reset, low
    input  wire logic      CTRL_IN,            // control pin, async
    input  wire logic      SWN_OVP_IN,         // comparator: switch_node above threshold
    input  wire logic      CSF_LOW_IN,         // comparator: current_sense_feedback below half
    input  wire logic      UVLO_IN,            // supply below threshold (with hysteresis)
    output logic           SW_TICK_OUT,        // switching cycle start pulse
    output logic           SW_EN_OUT,          // switch allowed to run
    output logic           HALF_LIM_OUT,       // half current limit active
    output logic [7:0]     TARGET_OUT,         // filtered regulation target code
    output logic [7:0]     RAMP_OUT,           // staircase ceiling code
    output logic [15:0]    OVP_MV_OUT,         // threshold for comparator, mV
    output logic           FAULT_OUT           // open fault latched
);
    typedef enum {LBCS_OFF, LBCS_RUN, LBCS_FAULT} lbcs_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [2:0] ctrl_sync_reg, ctrl_sync_next;
    logic [2:0] ovp_sync_reg,  ovp_sync_next;
    logic [2:0] csf_sync_reg,  csf_sync_next;
    logic [2:0] uv_sync_reg,   uv_sync_next;
    logic       ctrl_reg, ctrl_next, ovp_reg, ovp_next;
    logic       csf_reg, csf_next, uv_reg, uv_next;

    always_comb begin
        ctrl_sync_next = {ctrl_sync_reg[1:0], CTRL_IN};
        ovp_sync_next  = {ovp_sync_reg[1:0], SWN_OVP_IN};
        csf_sync_next  = {csf_sync_reg[1:0], CSF_LOW_IN};
        uv_sync_next   = {uv_sync_reg[1:0], UVLO_IN};
        // change counts once stage two and three agree
        ctrl_next = (ctrl_sync_reg[1] == ctrl_sync_reg[2]) ? ctrl_sync_reg[2] : ctrl_reg;
        ovp_next  = (ovp_sync_reg[1] == ovp_sync_reg[2]) ? ovp_sync_reg[2] : ovp_reg;
        csf_next  = (csf_sync_reg[1] == csf_sync_reg[2]) ? csf_sync_reg[2] : csf_reg;
        uv_next   = (uv_sync_reg[1] == uv_sync_reg[2]) ? uv_sync_reg[2] : uv_reg;
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ctrl_sync_reg <= 3'h_0;
            ovp_sync_reg  <= 3'h_0;
            csf_sync_reg  <= 3'h_0;
            uv_sync_reg   <= 3'h_7;
            ctrl_reg      <= 1'b0;
            ovp_reg       <= 1'b0;
            csf_reg       <= 1'b0;
            uv_reg        <= 1'b1;
        end else begin
            ctrl_sync_reg <= ctrl_sync_next;
            ovp_sync_reg  <= ovp_sync_next;
            csf_sync_reg  <= csf_sync_next;
            uv_sync_reg   <= uv_sync_next;
            ctrl_reg      <= ctrl_next;
            ovp_reg       <= ovp_next;
            csf_reg       <= csf_next;
            uv_reg        <= uv_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // switching tick, state, timers
    lbcs_state_t state_reg, state_next;
    logic [5:0]  div_reg, div_next;
    logic        tick;
    logic [31:0] off_cnt_reg, off_cnt_next;
    logic [31:0] half_cnt_reg, half_cnt_next;
    logic [31:0] step_cnt_reg, step_cnt_next;
    logic [5:0]  step_reg, step_next;
    logic [3:0]  open_cnt_reg, open_cnt_next;
    logic        ctrl_d_reg;
    logic        long_low, open_cyc, start;

    assign tick     = (div_reg == 6'(lbcs_pkg::SW_DIV - 1));
    assign long_low = (off_cnt_reg >= 32'(OFF_CYCLES));
    // rising edge of the settled control level starts the device
    assign start    = ctrl_reg && !ctrl_d_reg && !uv_reg;
    assign open_cyc = ovp_reg && csf_reg;

    always_comb begin
        div_next      = tick ? 6'h_00 : div_reg + 6'h_01;
        state_next    = state_reg;
        off_cnt_next  = ctrl_reg ? 32'h_0000_0000 : off_cnt_reg + {31'h_0, !long_low};
        open_cnt_next = open_cnt_reg;
        half_cnt_next = half_cnt_reg;
        step_cnt_next = step_cnt_reg;
        step_next     = step_reg;
        case (state_reg)
            LBCS_OFF: begin
                // a high level after uv release also counts as enable
                if (ctrl_reg && !uv_reg && (start || !long_low)) begin
                    state_next    = LBCS_RUN;
                    half_cnt_next = 32'h_0000_0000;
                    step_cnt_next = 32'h_0000_0000;
                    step_next     = 6'h_00;
                    open_cnt_next = 4'h_0;
                end
            end
            LBCS_RUN: begin
                if (half_cnt_reg < 32'(HALF_CYCLES)) begin
                    half_cnt_next = half_cnt_reg + 32'h_0000_0001;
                end
                if (step_reg < 6'(lbcs_pkg::RAMP_STEPS)) begin
                    if (step_cnt_reg == 32'(STEP_CYCLES - 1)) begin
                        step_cnt_next = 32'h_0000_0000;
                        step_next     = step_reg + 6'h_01;
                    end else begin
                        step_cnt_next = step_cnt_reg + 32'h_0000_0001;
                    end
                end
                if (tick) begin
                    // any clean cycle restarts the run
                    open_cnt_next = open_cyc ? open_cnt_reg + 4'h_1 : 4'h_0;
                end
                if (uv_reg) begin
                    state_next = LBCS_OFF;
                end else if (open_cnt_reg == 4'(lbcs_pkg::OPEN_RUN)) begin
                    state_next = LBCS_FAULT;
                end else if (long_low) begin
                    state_next = LBCS_OFF;
                end
            end
            LBCS_FAULT: begin
                // a fresh rising edge of the pin clears the latch; undervoltage drops it to off
                if (start) begin
                    state_next    = LBCS_RUN;
                    half_cnt_next = 32'h_0000_0000;
                    step_cnt_next = 32'h_0000_0000;
                    step_next     = 6'h_00;
                    open_cnt_next = 4'h_0;
                end else if (uv_reg) begin
                    state_next = LBCS_OFF;
                end
            end
            default: state_next = LBCS_OFF;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            state_reg    <= LBCS_OFF;
            div_reg      <= 6'h_00;
            off_cnt_reg  <= 32'h_0000_0000;
            half_cnt_reg <= 32'h_0000_0000;
            step_cnt_reg <= 32'h_0000_0000;
            step_reg     <= 6'h_00;
            open_cnt_reg <= 4'h_0;
            ctrl_d_reg   <= 1'b0;
        end else begin
            state_reg    <= state_next;
            div_reg      <= div_next;
            off_cnt_reg  <= off_cnt_next;
            half_cnt_reg <= half_cnt_next;
            step_cnt_reg <= step_cnt_next;
            step_reg     <= step_next;
            open_cnt_reg <= open_cnt_next;
            ctrl_d_reg   <= ctrl_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gated reference and low-pass filter
    logic [7:0]  ramp;
    logic [7:0]  gated;
    logic [15:0] filt_reg, filt_next;
    logic [7:0]  tgt_reg, tgt_next;
    logic        run;

    assign run   = (state_reg == LBCS_RUN);
    // staircase of 32 equal steps, top step reaches full code
    assign ramp  = (step_reg >= 6'(lbcs_pkg::RAMP_STEPS)) ? lbcs_pkg::TGT_FULL
                   : {step_reg[4:0], 3'h_0};
    assign gated = (run && ctrl_reg) ? ramp : 8'h_00;

    always_comb begin
        // first-order iir, time constant 64 clocks; only pwm periods well below that leave little ripple
        filt_next = run ? filt_reg + 16'({gated, 8'h_00} >> lbcs_pkg::FILT_SHIFT)
                        - (filt_reg >> lbcs_pkg::FILT_SHIFT) : 16'h_0000;
        tgt_next  = filt_next[15:8];
    end

    always_ff @(posedge CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            filt_reg <= 16'h_0000;
            tgt_reg  <= 8'h_00;
        end else begin
            filt_reg <= filt_next;
            tgt_reg  <= tgt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign SW_TICK_OUT  = tick;
    assign SW_EN_OUT    = run;
    assign HALF_LIM_OUT = run && (half_cnt_reg < 32'(HALF_CYCLES));
    assign TARGET_OUT   = tgt_reg;
    assign RAMP_OUT     = run ? ramp : 8'h_00;
    assign OVP_MV_OUT   = HIGH_VARIANT ? 16'(lbcs_pkg::OVP_HIGH_MV)
                                       : 16'(lbcs_pkg::OVP_LOW_MV);
    assign FAULT_OUT    = (state_reg == LBCS_FAULT);

    ////////////////////////////////////////////////////////////////////////////
    // assertions
    sequence open_run_s;
        tick && open_cyc && run;
    endsequence

    AST_UV_OFF: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        uv_reg |=> !SW_EN_OUT)
        else $error("switch enabled under undervoltage");
    AST_FAULT_HOLD: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        FAULT_OUT && !start && !uv_reg |=> FAULT_OUT)
        else $error("fault latch released without toggle");
    AST_OPEN_CLR: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        run && tick && !open_cyc |=> open_cnt_reg == 4'h_0)
        else $error("open counter not cleared");
    AST_OPEN_CNT: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        open_run_s and (open_cnt_reg == 4'h_3) |=> open_cnt_reg == 4'h_4)
        else $error("open counter did not advance");
    AST_FAULT_ENTRY: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        run && !uv_reg && open_cnt_reg == 4'h_8 |=> FAULT_OUT && !SW_EN_OUT)
        else $error("no shutdown after open run");
    AST_LONG_LOW: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        run && long_low && !uv_reg && open_cnt_reg != 4'h_8 |=> !SW_EN_OUT)
        else $error("no shutdown after long low");
    AST_OFF_CLR: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        ctrl_reg |=> off_cnt_reg == 32'h_0000_0000)
        else $error("off timer not cleared");
    AST_RESTART: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !run ##1 run |-> step_reg == 6'h_00 && HALF_LIM_OUT)
        else $error("enable did not restart soft start");
    AST_GATE: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        run && !ctrl_reg |-> gated == 8'h_00)
        else $error("reference not chopped");
    AST_TICK: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        tick |=> !tick [*8])
        else $error("switching tick too frequent");

    ////////////////////////////////////////////////////////////////////////////
    // staircase, timer, filter and fault checks
    // staircase advance is the step most likely to slip by a cycle
    sequence step_due_s;
        run && !uv_reg && !long_low && (open_cnt_reg != 4'h_8);
    endsequence

    sequence step_end_s;
        (step_reg < 6'(lbcs_pkg::RAMP_STEPS)) && (step_cnt_reg == 32'(STEP_CYCLES - 1));
    endsequence

    AST_STEP_UP: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        step_due_s and step_end_s |=> step_reg == $past(step_reg) + 6'h_01)
        else $error("staircase did not advance");

    AST_STEP_HOLD: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        step_due_s and (step_cnt_reg != 32'(STEP_CYCLES - 1)) |=> $stable(step_reg))
        else $error("staircase moved early");

    AST_HALF_END: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        run && (half_cnt_reg >= 32'(HALF_CYCLES)) |=> !HALF_LIM_OUT)
        else $error("half limit not restored");

    AST_OFF_COUNT: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !ctrl_reg && !long_low |=> off_cnt_reg == $past(off_cnt_reg) + 32'h_0000_0001)
        else $error("off timer did not count");

    AST_FILT_CLR: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        !run |=> filt_reg == 16'h_0000)
        else $error("filter not cleared when stopped");

    AST_FULL_REF: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        run && ctrl_reg && (step_reg >= 6'(lbcs_pkg::RAMP_STEPS)) |-> gated == lbcs_pkg::TGT_FULL)
        else $error("full reference not applied");

    // undervoltage must also drop a latched fault
    AST_FAULT_UV: assert property (@(posedge CLK_IN) disable iff (!NRST_IN)
        FAULT_OUT && uv_reg |=> !FAULT_OUT && !SW_EN_OUT)
        else $error("fault kept under undervoltage");
endmodule

// ===== verif/lbcs_host_pwm.sv
// host pwm source model driving the control pin
`timescale 1ns/1ns
module lbcs_host_pwm (
    input  wire logic        clk_in,    // bench clock
    input  wire logic        pwm_in,    // chop enable
    input  wire logic        level_in,  // steady level when not chopping
    input  wire logic [15:0] period_in, // chop period in clocks
    input  wire logic [15:0] high_in,   // high clocks per period
    output logic             ctrl_out   // control pin drive
);
    logic [15:0] cnt_reg = 16'h_0000;
    // clean full-swing edges only, never an rc-filtered level
    always @(posedge clk_in) begin
        cnt_reg <= (pwm_in && cnt_reg < period_in - 16'h_0001) ? cnt_reg + 16'h_0001 : 16'h_0000;
        ctrl_out <= pwm_in ? (cnt_reg < high_in) : level_in;
    end
endmodule

// ===== verif/lbcs_top_bench.sv
// self-checking bench for the led boost control sequencer
`timescale 1ns/1ns
module lbcs_top_bench;
    localparam int OFF  = 200;
    localparam int HALF = 400;
    localparam int STEP = 20;
    logic        clk, nrst, ovp, csf, uvlo, pwm, lvl, ctrl;
    logic        tick, sw_en, half, fault;
    logic [15:0] per, hi, ovp_mv, ovp_mv_hi;
    logic [7:0]  tgt, ramp;
    logic [31:0] acc;
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          k;
    int          stp[7] = '{1, 7, 19, 21, 31, 32, 40};
    int          hd[2];

    lbcs_top #(.OFF_CYCLES(OFF), .HALF_CYCLES(HALF), .STEP_CYCLES(STEP)) uut (
        .CLK_IN(clk), .NRST_IN(nrst), .CTRL_IN(ctrl), .SWN_OVP_IN(ovp), .CSF_LOW_IN(csf),
        .UVLO_IN(uvlo), .SW_TICK_OUT(tick), .SW_EN_OUT(sw_en), .HALF_LIM_OUT(half),
        .TARGET_OUT(tgt), .RAMP_OUT(ramp), .OVP_MV_OUT(ovp_mv), .FAULT_OUT(fault));

    // second variant only to see its threshold
    lbcs_top #(.HIGH_VARIANT(1'b1)) uut_hi (
        .CLK_IN(clk), .NRST_IN(nrst), .CTRL_IN(ctrl), .SWN_OVP_IN(ovp), .CSF_LOW_IN(csf),
        .UVLO_IN(uvlo), .SW_TICK_OUT(), .SW_EN_OUT(), .HALF_LIM_OUT(),
        .TARGET_OUT(), .RAMP_OUT(), .OVP_MV_OUT(ovp_mv_hi), .FAULT_OUT());

    lbcs_host_pwm host (.clk_in(clk), .pwm_in(pwm), .level_in(lvl), .period_in(per),
        .high_in(hi), .ctrl_out(ctrl));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ramp_at(int s);
        return (s >= lbcs_pkg::RAMP_STEPS) ? 32'h_00FF : 32'(s * 8);
    endfunction
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk_in(string what, logic [31:0] lo, logic [31:0] up, logic [31:0] got);
        @(negedge clk);
        n_compared++;
        if ((got >= lo && got <= up) !== 1'b1) begin
            bad_count++;
            $display("[ERR] %s expected %0h..%0h seen %0h", what, lo, up, got);
        end
    endtask
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        chk_in(what, exp, exp, got);
    endtask
    task automatic wt(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wait_for(logic v, int lim);
        for (int i = 0; i < lim && sw_en !== v; i++) @(negedge clk);
        chk("sw_en", 32'(v), 32'(sw_en));
    endtask
    task automatic wait_tick();
        @(negedge clk);
        for (int i = 0; i < 100 && tick !== 1'b1; i++) @(negedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // runaway guard, well above the roughly 9000 cycles the tests take
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        nrst = 0; ovp = 0; csf = 0; uvlo = 0; pwm = 0; lvl = 0;
        per = 16'h_00FA;
        hi = 16'h_0000;
        void'($urandom(99));
        wt(4);
        nrst <= 1'b1;
        chk("ovp_mv", 32'(lbcs_pkg::OVP_LOW_MV), 32'(ovp_mv));
        chk("ovp_mv high", 32'(lbcs_pkg::OVP_HIGH_MV), 32'(ovp_mv_hi));
        chk("sw_en idle", 0, 32'(sw_en));
        wait_tick();
        k = cyc;
        wait_tick();
        chk("tick period", 32'(lbcs_pkg::SW_DIV), 32'(cyc - k));
        wt(1);
        lvl <= 1'b1;
        wait_for(1'b1, 12);
        k = cyc;
        chk("ramp start", 0, 32'(ramp));
        foreach (stp[i]) begin
            wt(k + stp[i] * STEP + STEP / 2 - cyc);
            chk("ramp", ramp_at(stp[i]), 32'(ramp));
            chk("half", 32'(stp[i] * STEP + STEP / 2 < HALF), 32'(half));
        end
        wt(600);
        chk_in("target full", 32'h_00F0, 32'h_00FF, 32'(tgt));
        // dimming inside the 5kHz..100kHz band, lows kept under the shutdown delay
        hd[0] = 60 + $urandom % 141;
        hd[1] = 240;
        foreach (hd[i]) begin
            wt(1);
            hi <= 16'(hd[i]);
            pwm <= 1'b1;
            wt(1500);
            acc = 0;
            repeat (1000) begin
                @(negedge clk);
                acc += 32'(tgt);
            end
            k = hd[i] * 255 / 250;
            chk_in("pwm target", 32'(k - 20), 32'(k + 20), acc / 1000);
            chk("sw_en dim", 1, 32'(sw_en));
        end
        wt(1);
        pwm <= 1'b0;
        wt(40);
        lvl <= 1'b0;
        wt(OFF - 30);
        lvl <= 1'b1;
        wt(20);
        lvl <= 1'b0;
        wt(OFF - 30);
        lvl <= 1'b1;
        wt(10);
        chk("sw_en short lows", 1, 32'(sw_en));
        wt(1);
        lvl <= 1'b0;
        wt(OFF + 30);
        chk("sw_en long low", 0, 32'(sw_en));
        wt(1);
        lvl <= 1'b1;
        wait_for(1'b1, 12);
        wt(1);
        ovp <= 1'b1;
        csf <= 1'b1;
        wt(6 * 41);
        csf <= 1'b0;
        wt(41);
        csf <= 1'b1;
        wt(6 * 41);
        chk("fault broken run", 0, 32'(fault));
        wt(1);
        ovp <= 1'b0;
        wt(12 * 41);
        chk("fault one cond", 0, 32'(fault));
        wt(1);
        ovp <= 1'b1;
        wt(12 * 41);
        chk("fault latched", 1, 32'(fault));
        chk("sw_en fault", 0, 32'(sw_en));
        wt(1);
        ovp <= 1'b0;
        csf <= 1'b0;
        wt(100);
        chk("fault held high", 1, 32'(fault));
        wt(1);
        lvl <= 1'b0;
        wt(10);
        lvl <= 1'b1;
        wait_for(1'b1, 15);
        chk("fault cleared", 0, 32'(fault));
        chk("ramp restart", 0, 32'(ramp));
        wt(100);
        uvlo <= 1'b1;
        wait_for(1'b0, 10);
        wt(50);
        uvlo <= 1'b0;
        wait_for(1'b1, 12);
        chk("ramp uv restart", 0, 32'(ramp));
        chk("half uv rearm", 1, 32'(half));
        close_out();
    end
endmodule
